// *** common/refresh_timer_pkg.sv ***
// package: register map, field layout, reset values and state types of the refresh timer
package refresh_timer_pkg;
  // register byte addresses (one aligned 32-bit word each)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_PERIOD = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int ADDR_W = 4;
  // control register field positions
  localparam int POS_CLK_SEL = 8;
  localparam int POS_REFRESH_ON = 7;
  localparam int POS_CMF = 15;
  localparam int POS_COMPARE_MATCH_IRQ_EN = 14;
  localparam int POS_WAIT = 4;
  localparam int POS_SELFREF = 3;
  localparam int POS_POSTPRE = 0;
  localparam int POS_PRECHARGE = 16;
  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // prescaler: widest divide is 4096
  localparam int PRESCALE_W = 12;
  // refresh and post-self-refresh precharge cycles: base states before waits or extra states are added
  localparam logic [2:0] REFRESH_BASE_STATES = 3'h2;
  localparam logic [3:0] PRECHARGE_BASE_STATES = 4'h1;

  typedef enum logic [1:0] {
    SEQ_IDLE, SEQ_REFRESH, SEQ_SELFREF, SEQ_PRECHARGE
  } seq_state_e;

  // software-visible configuration
  typedef struct packed {
    logic [2:0] clk_sel;
    logic refresh_on;
    logic compare_match_irq_en;
    logic [1:0] wait_sel;
    logic self_refresh_en;
    logic [2:0] post_pre;
    logic [1:0] precharge;
  } config_s;

  // memory-side command strobes
  typedef struct packed {
    logic refresh_busy;
    logic self_refresh;
    logic precharge_busy;
  } mem_cmd_s;
endpackage : refresh_timer_pkg

// *** src/refresh_prescaler.sv ***
// file: free-running prescaler that yields the selected count enable
`timescale 1ns/10ps
module refresh_prescaler
  import refresh_timer_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hw_standby,
  // selection and result
  input wire logic [2:0] clk_sel,
  output logic tick
);
  typedef struct packed {
    logic [PRESCALE_W-1:0] div;
    logic tick;
  } pre_s;
  pre_s st_reg;
  pre_s st_next;
  logic [PRESCALE_W-1:0] div_inc;

  // tick when the low bits of the divider wrap; code 000 halts the count
  always_comb begin
    st_next = st_reg;
    div_inc = st_reg.div + 1'b1;
    st_next.div = div_inc;
    unique case (clk_sel)
      3'h0: st_next.tick = 1'b0;
      3'h1: st_next.tick = (div_inc[0:0] == '0);
      3'h2: st_next.tick = (div_inc[2:0] == '0);
      3'h3: st_next.tick = (div_inc[4:0] == '0);
      3'h4: st_next.tick = (div_inc[6:0] == '0);
      3'h5: st_next.tick = (div_inc[8:0] == '0);
      3'h6: st_next.tick = (div_inc[10:0] == '0);
      3'h7: st_next.tick = (div_inc[11:0] == '0);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || hw_standby) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  AST_HALT_NO_TICK: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (clk_sel == 3'h0) ##1 (clk_sel == 3'h0) |-> !tick)
    else $error("prescaler ticked while halted");
endmodule : refresh_prescaler

// *** src/refresh_timer_control.sv ***
// file: refresh timer, compare logic, refresh sequencing and Avalon-MM registers
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - refresh wait code 00..11 inserts zero to three wait states per refresh cycle.
// - one wait setting applies to all DRAM and synchronous DRAM areas.
// - self-refresh enable set enters self-refresh on software standby.
// - self-refresh enable acts only while refresh is on.
// - hardware clears self-refresh enable after leaving software standby; the code clears it only on leaving self-refresh.
// - post-self-refresh code adds zero to seven precharge states.
// - those extra states add to the normal two-bit precharge count.
// - counter is an 8-bit software read/write up-counter.
// - counter increments on the prescaled clock chosen by clock select.
// - match sets the compare flag and clears the counter to 00.
// - match with refresh on starts a refresh cycle.
// - match with refresh off and interrupt enable raises the interrupt.
// - counter resets to 00 on reset and hardware standby.
// - counter and period keep their values through software standby; the counter still advances on prescaler ticks during it.
// - period constant is an 8-bit software read/write register.
// - counter and period are compared every cycle.
// - period resets to FF on reset and hardware standby.
// - clock select 000 halts; others divide by 2 up to 4096.
// - with refresh off the timer works as a plain interval timer.
module refresh_timer_control
  import refresh_timer_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // chip power states (same clock domain)
  input wire logic hw_standby,
  input wire logic sw_standby,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // memory side
  output logic refresh_busy,
  output logic self_refresh,
  output logic precharge_busy,
  // interrupt
  output logic compare_match_irq
);
  typedef struct packed {
    config_s cfg;
    logic [7:0] count;
    logic [7:0] period;
    logic compare_match_flag;
    logic irq;
    seq_state_e seq;
    logic [3:0] seq_cnt;
    logic post_selfref;
    logic [31:0] rdata;
    logic ack;
    mem_cmd_s cmd;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic tick;
  logic match;
  logic access;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic [31:0] ctrl_word;

  refresh_prescaler u_pre (
    .core_clk(core_clk),
    .resetn(resetn),
    .hw_standby(hw_standby),
    .clk_sel(st_reg.cfg.clk_sel),
    .tick(tick)
  );

  // a request is answered one cycle after it appears: waitrequest starts high
  assign access = (avs_read || avs_write) && !st_reg.ack;
  assign wr_ctrl = access && avs_write && (avs_address == ADDR_CONTROL);
  assign wr_count = access && avs_write && (avs_address == ADDR_COUNT) && avs_byteenable[0];
  assign wr_period = access && avs_write && (avs_address == ADDR_PERIOD) && avs_byteenable[0];
  assign match = (st_reg.count == st_reg.period);

  // control word as software sees it
  always_comb begin
    ctrl_word = '0;
    ctrl_word[POS_CLK_SEL +: 3] = st_reg.cfg.clk_sel;
    ctrl_word[POS_REFRESH_ON] = st_reg.cfg.refresh_on;
    ctrl_word[POS_CMF] = st_reg.compare_match_flag;
    ctrl_word[POS_COMPARE_MATCH_IRQ_EN] = st_reg.cfg.compare_match_irq_en;
    ctrl_word[POS_WAIT +: 2] = st_reg.cfg.wait_sel;
    ctrl_word[POS_SELFREF] = st_reg.cfg.self_refresh_en;
    ctrl_word[POS_POSTPRE +: 3] = st_reg.cfg.post_pre;
    ctrl_word[POS_PRECHARGE +: 2] = st_reg.cfg.precharge;
  end

  // whole next-state computation
  always_comb begin
    st_next = st_reg;
    st_next.ack = access;
    // bus read capture
    st_next.rdata = UNMAPPED_DATA;
    if (access && avs_read) begin
      unique case (avs_address)
        ADDR_CONTROL: st_next.rdata = ctrl_word;
        ADDR_COUNT: st_next.rdata = {24'h000000, st_reg.count};
        ADDR_PERIOD: st_next.rdata = {24'h000000, st_reg.period};
        ADDR_STATUS: st_next.rdata = {30'h0, st_reg.post_selfref, st_reg.cmd.self_refresh};
        default: st_next.rdata = UNMAPPED_DATA;
      endcase
    end
    // configuration writes, byte lane by lane
    if (wr_ctrl && avs_byteenable[0]) begin
      st_next.cfg.refresh_on = avs_writedata[POS_REFRESH_ON];
      st_next.cfg.wait_sel = avs_writedata[POS_WAIT +: 2];
      st_next.cfg.self_refresh_en = avs_writedata[POS_SELFREF];
      st_next.cfg.post_pre = avs_writedata[POS_POSTPRE +: 3];
    end
    if (wr_ctrl && avs_byteenable[1]) begin
      st_next.cfg.clk_sel = avs_writedata[POS_CLK_SEL +: 3];
      st_next.cfg.compare_match_irq_en = avs_writedata[POS_COMPARE_MATCH_IRQ_EN];
    end
    if (wr_ctrl && avs_byteenable[2]) begin
      st_next.cfg.precharge = avs_writedata[POS_PRECHARGE +: 2];
    end
    // flag: writing 0 to it clears; a match in the same cycle wins
    if (wr_ctrl && avs_byteenable[1] && !avs_writedata[POS_CMF]) begin
      st_next.compare_match_flag = 1'b0;
    end
    // counter: software write, tick increment, match clear
    if (wr_count) begin
      st_next.count = avs_writedata[7:0];
    end else if (match) begin
      st_next.count = COUNT_RESET;
    end else if (tick) begin
      st_next.count = st_reg.count + 8'h01;
    end
    if (wr_period) begin
      st_next.period = avs_writedata[7:0];
    end
    if (match) begin
      st_next.compare_match_flag = 1'b1;
    end
    // interrupt only in interval timer mode
    st_next.irq = st_next.compare_match_flag && st_next.cfg.compare_match_irq_en && !st_next.cfg.refresh_on;
    // refresh and self-refresh sequencing
    unique case (st_reg.seq)
      SEQ_IDLE: begin
        if (sw_standby && st_reg.cfg.self_refresh_en && st_reg.cfg.refresh_on) begin
          st_next.seq = SEQ_SELFREF;
        end else if (match && st_reg.cfg.refresh_on) begin
          st_next.seq = SEQ_REFRESH;
          st_next.seq_cnt = {1'b0, REFRESH_BASE_STATES} + {2'b00, st_reg.cfg.wait_sel};
        end
      end
      SEQ_REFRESH: begin
        if (st_reg.seq_cnt == 4'h1) begin
          st_next.seq = SEQ_IDLE;
        end
        st_next.seq_cnt = st_reg.seq_cnt - 4'h1;
      end
      SEQ_SELFREF: begin
        if (!sw_standby) begin
          st_next.seq = SEQ_PRECHARGE;
          st_next.cfg.self_refresh_en = 1'b0;
          st_next.post_selfref = 1'b1;
          st_next.seq_cnt = PRECHARGE_BASE_STATES + {2'b00, st_reg.cfg.precharge}
            + {1'b0, st_reg.cfg.post_pre};
        end
      end
      SEQ_PRECHARGE: begin
        if (st_reg.seq_cnt == 4'h1) begin
          st_next.seq = SEQ_IDLE;
        end
        st_next.seq_cnt = st_reg.seq_cnt - 4'h1;
      end
    endcase
    st_next.cmd.refresh_busy = (st_next.seq == SEQ_REFRESH);
    st_next.cmd.self_refresh = (st_next.seq == SEQ_SELFREF);
    st_next.cmd.precharge_busy = (st_next.seq == SEQ_PRECHARGE);
  end

  // hardware standby reinitialises like reset; software standby keeps state
  always_ff @(posedge core_clk) begin
    if (!resetn || hw_standby) begin
      st_reg <= '0;
      st_reg.count <= COUNT_RESET;
      st_reg.period <= PERIOD_RESET;
      st_reg.seq <= SEQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = !st_reg.ack;
  assign refresh_busy = st_reg.cmd.refresh_busy;
  assign self_refresh = st_reg.cmd.self_refresh;
  assign precharge_busy = st_reg.cmd.precharge_busy;
  assign compare_match_irq = st_reg.irq;

  // lengths are judged on the wait code that was live when the cycle was launched
  AST_MATCH_CLEARS: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    (st_reg.count == st_reg.period) && !wr_count |=> (st_reg.count == COUNT_RESET) && st_reg.compare_match_flag)
    else $error("match did not clear counter and set flag");
  AST_REFRESH_START: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    match && st_reg.cfg.refresh_on && st_reg.seq == SEQ_IDLE && !sw_standby |=> refresh_busy)
    else $error("refresh did not start");
  AST_REFRESH_LEN0: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(refresh_busy) && $past(st_reg.cfg.wait_sel) == 2'b00 |-> refresh_busy[*2] ##1 !refresh_busy)
    else $error("refresh length wrong for zero waits");
  AST_REFRESH_LEN3: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(refresh_busy) && $past(st_reg.cfg.wait_sel) == 2'b11 |-> refresh_busy[*5] ##1 !refresh_busy)
    else $error("refresh length wrong for three waits");
  AST_IRQ_MODE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    compare_match_irq |-> st_reg.compare_match_flag && st_reg.cfg.compare_match_irq_en && !st_reg.cfg.refresh_on)
    else $error("interrupt without its cause");
  AST_FLAG_STICKY: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    st_reg.compare_match_flag && !wr_ctrl |=> st_reg.compare_match_flag)
    else $error("compare flag dropped by itself");
  AST_SELFREF_GATE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(self_refresh) |-> $past(st_reg.cfg.refresh_on) && $past(st_reg.cfg.self_refresh_en))
    else $error("self-refresh entered while not enabled");
  AST_SELFREF_CLEAR: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $fell(self_refresh) |-> !st_reg.cfg.self_refresh_en && precharge_busy)
    else $error("self-refresh enable not cleared on exit");
  AST_PERIOD_WRITE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    wr_period |=> st_reg.period == $past(avs_writedata[7:0]))
    else $error("period write lost");

  // counter and period between matches
  AST_COUNT_TICK: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    tick && !match && !wr_count |=> st_reg.count == $past(st_reg.count) + 8'h01)
    else $error("counter missed a prescaler tick");
  AST_COUNT_HOLD: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    !tick && !match && !wr_count |=> $stable(st_reg.count))
    else $error("counter moved without a tick");
  AST_COUNT_WRITE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    wr_count |=> st_reg.count == $past(avs_writedata[7:0]))
    else $error("counter write lost");
  AST_PERIOD_HOLD: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    !wr_period |=> $stable(st_reg.period))
    else $error("period changed without a write");
  AST_PERIOD_STANDBY: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    sw_standby && !wr_period |=> $stable(st_reg.period))
    else $error("period lost in software standby");
  AST_COUNT_STANDBY: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    sw_standby && !tick && !match && !wr_count |=> $stable(st_reg.count))
    else $error("counter lost in software standby");
  // reset checks run without a disable so that they see the reset itself
  AST_RESET_COUNT: assert property (@(posedge core_clk)
    !resetn || hw_standby |=> st_reg.count == COUNT_RESET)
    else $error("counter not cleared by reset");
  AST_RESET_PERIOD: assert property (@(posedge core_clk)
    !resetn || hw_standby |=> st_reg.period == PERIOD_RESET)
    else $error("period not preset by reset");

  // flag and interrupt
  AST_IRQ_SET: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    match && st_reg.cfg.compare_match_irq_en && !st_reg.cfg.refresh_on && !wr_ctrl |=> compare_match_irq)
    else $error("interrupt not raised on match");
  AST_IRQ_QUIET: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    st_reg.cfg.refresh_on |-> !compare_match_irq)
    else $error("interrupt raised with refresh on");
  AST_FLAG_CLEAR: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    wr_ctrl && avs_byteenable[1] && !avs_writedata[POS_CMF] && !match |=> !st_reg.compare_match_flag)
    else $error("compare flag not cleared by write");
  AST_IRQ_HOLD: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    compare_match_irq && !wr_ctrl |=> compare_match_irq)
    else $error("interrupt dropped by itself");

  // refresh sequencing
  AST_REFRESH_LEN1: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(refresh_busy) && $past(st_reg.cfg.wait_sel) == 2'b01 |-> refresh_busy[*3] ##1 !refresh_busy)
    else $error("refresh length wrong for one wait");
  AST_REFRESH_LEN2: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(refresh_busy) && $past(st_reg.cfg.wait_sel) == 2'b10 |-> refresh_busy[*4] ##1 !refresh_busy)
    else $error("refresh length wrong for two waits");
  AST_REFRESH_CAUSE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(refresh_busy) |-> $past(match) && $past(st_reg.cfg.refresh_on))
    else $error("refresh started without a match");
  AST_REFRESH_ALONE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    self_refresh || precharge_busy |-> !refresh_busy)
    else $error("refresh overlaps self-refresh");

  // self-refresh entry, stay and exit precharge
  AST_SELFREF_ENTRY: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    st_reg.seq == SEQ_IDLE && sw_standby && st_reg.cfg.self_refresh_en && st_reg.cfg.refresh_on
    |=> self_refresh)
    else $error("self-refresh not entered");
  AST_SELFREF_HOLD: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    self_refresh && sw_standby |=> self_refresh)
    else $error("self-refresh left during standby");
  AST_SELFREF_OFF: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    st_reg.seq == SEQ_IDLE && !st_reg.cfg.refresh_on |=> !self_refresh)
    else $error("self-refresh entered with refresh off");
  AST_PRE_LEN_MIN: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(precharge_busy) && $past(st_reg.cfg.post_pre) == 3'h0 && $past(st_reg.cfg.precharge) == 2'h0
    |-> precharge_busy ##1 !precharge_busy)
    else $error("precharge length wrong for no extra states");
  AST_PRE_LEN_MAX: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(precharge_busy) && $past(st_reg.cfg.post_pre) == 3'h7 && $past(st_reg.cfg.precharge) == 2'h0
    |-> precharge_busy[*8] ##1 !precharge_busy)
    else $error("precharge length wrong for seven extra states");
  AST_PRE_LEN_SUM: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    $rose(precharge_busy) && $past(st_reg.cfg.post_pre) == 3'h5 && $past(st_reg.cfg.precharge) == 2'h2
    |-> precharge_busy[*8] ##1 !precharge_busy)
    else $error("extra states not added to precharge count");

  // register bus: one wait state, then a single answer cycle
  AST_BUS_ANSWER: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  AST_BUS_SINGLE: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood longer than one cycle");
  AST_READ_COUNT: assert property (@(posedge core_clk)
    disable iff (!resetn || hw_standby)
    access && avs_read && avs_address == ADDR_COUNT |=> avs_readdata[7:0] == $past(st_reg.count))
    else $error("counter read returned wrong value");
endmodule : refresh_timer_control

// *** tb/dram_refresh_timer_control_bench.sv ***
// file: self-checking bench for the refresh timer block
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module dram_refresh_timer_control_bench;
  import refresh_timer_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic refresh_busy;
  logic self_refresh;
  logic precharge_busy;
  logic compare_match_irq;
  int ref_cnt, ref_len, pre_len, clash_cnt;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  int n;
  refresh_timer_control refresh_timer_control_inst (.core_clk(core_clk), .resetn(resetn),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .refresh_busy(refresh_busy),
    .self_refresh(self_refresh), .precharge_busy(precharge_busy),
    .compare_match_irq(compare_match_irq));
  mem_model mem_model_inst (.core_clk(core_clk), .refresh_busy(refresh_busy),
    .self_refresh(self_refresh), .precharge_busy(precharge_busy), .ref_cnt(ref_cnt),
    .ref_len(ref_len), .pre_len(pre_len), .clash_cnt(clash_cnt));
  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // hang guard: whole run needs a few hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // one Avalon-MM transfer; waitrequest and read data are taken at the same rising edge
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : av
  function automatic logic [31:0] ctl(logic [2:0] cs, logic on, logic ie, logic [1:0] w,
                                      logic sr, logic [2:0] pp, logic [1:0] pc);
    return {14'h0, pc, 1'b0, ie, 3'h0, cs, on, 1'b0, w, sr, pp};
  endfunction : ctl
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 300) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_for
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    av(1'b0, ADDR_COUNT, 32'h0, 4'hF);
    `CHK(q[7:0], 8'h00)
    av(1'b0, ADDR_PERIOD, 32'h0, 4'hF);
    `CHK(q[7:0], 8'hFF)
    av(1'b0, 4'h1, 32'h0, 4'hF);
    `CHK(q, UNMAPPED_DATA)
    // counter and period are plain read/write bytes; clock select 0 holds the count
    av(1'b1, ADDR_COUNT, 32'h5A, 4'h1);
    repeat (20) @(posedge core_clk);
    av(1'b0, ADDR_COUNT, 32'h0, 4'hF);
    `CHK(q[7:0], 8'h5A)
    av(1'b1, ADDR_PERIOD, 32'h0A, 4'h1);
    av(1'b0, ADDR_PERIOD, 32'h0, 4'hF);
    `CHK(q[7:0], 8'h0A)
    // interval timer: divide by 2, period 10, interrupt enabled
    av(1'b1, ADDR_COUNT, 32'h0, 4'h1);
    av(1'b1, ADDR_CONTROL, ctl(3'h1, 1'b0, 1'b1, 2'h0, 1'b0, 3'h0, 2'h0), 4'hF);
    wait_for(compare_match_irq, 1'b1);
    `CHK(compare_match_irq, 1'b1)
    av(1'b0, ADDR_COUNT, 32'h0, 4'hF);
    `CHK(q[7:0] < 8'h05, 1'b1)
    av(1'b0, ADDR_CONTROL, 32'h0, 4'hF);
    `CHK(q[POS_CMF], 1'b1)
    repeat (30) @(posedge core_clk);
    `CHK(compare_match_irq, 1'b1)
    // halt first, then clear, so that no match can land on the clearing write
    av(1'b1, ADDR_CONTROL, ctl(3'h0, 1'b0, 1'b1, 2'h0, 1'b0, 3'h0, 2'h0), 4'hF);
    av(1'b1, ADDR_CONTROL, ctl(3'h0, 1'b0, 1'b1, 2'h0, 1'b0, 3'h0, 2'h0), 4'hF);
    repeat (2) @(posedge core_clk);
    `CHK(compare_match_irq, 1'b0)
    // refresh cycles for each wait code; interrupt stays quiet with refresh on
    for (int w = 0; w < 4; w++) begin
      av(1'b1, ADDR_CONTROL, ctl(3'h1, 1'b1, 1'b1, w[1:0], 1'b0, 3'h0, 2'h0), 4'hF);
      n = ref_cnt;
      while (ref_cnt < n + 2 && cyc < 19000) @(posedge core_clk);
      `CHK(ref_len, 32'(REFRESH_BASE_STATES) + w)
      `CHK(compare_match_irq, 1'b0)
    end
    // self-refresh on standby, count frozen so it must survive untouched
    av(1'b1, ADDR_CONTROL, ctl(3'h0, 1'b1, 1'b0, 2'h0, 1'b1, 3'h5, 2'h2), 4'hF);
    av(1'b1, ADDR_COUNT, 32'h07, 4'h1);
    sw_standby <= 1'b1;
    wait_for(self_refresh, 1'b1);
    `CHK(self_refresh, 1'b1)
    av(1'b0, ADDR_COUNT, 32'h0, 4'hF);
    `CHK(q[7:0], 8'h07)
    sw_standby <= 1'b0;
    repeat (30) @(posedge core_clk);
    `CHK(pre_len, 32'(PRECHARGE_BASE_STATES) + 2 + 5)
    av(1'b0, ADDR_CONTROL, 32'h0, 4'hF);
    `CHK(q[POS_SELFREF], 1'b0)
    av(1'b0, ADDR_PERIOD, 32'h0, 4'hF);
    `CHK(q[7:0], 8'h0A)
    `CHK(clash_cnt, 0)
    // self-refresh enable is ignored while refresh is off
    av(1'b1, ADDR_CONTROL, ctl(3'h0, 1'b0, 1'b0, 2'h0, 1'b1, 3'h0, 2'h0), 4'hF);
    sw_standby <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK(self_refresh, 1'b0)
    sw_standby <= 1'b0;
    // hardware standby reinitialises counter and period
    hw_standby <= 1'b1;
    @(posedge core_clk);
    hw_standby <= 1'b0;
    @(posedge core_clk);
    av(1'b0, ADDR_COUNT, 32'h0, 4'hF);
    `CHK(q[7:0], COUNT_RESET)
    av(1'b0, ADDR_PERIOD, 32'h0, 4'hF);
    `CHK(q[7:0], PERIOD_RESET)
    end_of_test();
  end
endmodule : dram_refresh_timer_control_bench

// *** tb/mem_model.sv ***
// file: memory-side partner model that times refresh and precharge pulses
`timescale 1ns/10ps
module mem_model (
  // clock
  input wire logic core_clk,
  // memory commands
  input wire logic refresh_busy,
  input wire logic self_refresh,
  input wire logic precharge_busy,
  // measurements
  output int ref_cnt,
  output int ref_len,
  output int pre_len,
  output int clash_cnt
);
  int run_r;
  int run_p;
  initial begin
    ref_cnt = 0;
    ref_len = 0;
    pre_len = 0;
    clash_cnt = 0;
    run_r = 0;
    run_p = 0;
  end
  // measure each refresh and post-self-refresh precharge burst length
  always @(posedge core_clk) begin
    if (refresh_busy) begin
      run_r++;
    end else if (run_r != 0) begin
      ref_len <= run_r;
      ref_cnt <= ref_cnt + 1;
      run_r = 0;
    end
    if (precharge_busy) begin
      run_p++;
    end else if (run_p != 0) begin
      pre_len <= run_p;
      run_p = 0;
    end
    // a refresh while the memory sleeps would corrupt it
    if (self_refresh && refresh_busy) begin
      clash_cnt <= clash_cnt + 1;
    end
  end
endmodule : mem_model
